// >>> hw/ssc_cal_if.sv
`timescale 1ns/100ps
interface ssc_cal_if;
	logic start;
	logic busy;
	logic done;
	modport ctl (output start, input busy, input done);
	modport tmr (input start, output busy, output done);
endinterface : ssc_cal_if

// >>> hw/ssc_cal_timer.sv
`timescale 1ns/100ps
module ssc_cal_timer
	import ssc_pkg::*;
#(
	parameter logic [SSC_CAL_CNT_W-1:0] CYCLES = 17'h00001
)(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// calibration handshake
	ssc_cal_if.tmr cal
);

	typedef struct packed {
		ssc_cal_state_e state;
		logic [SSC_CAL_CNT_W-1:0] cnt;
		logic done;
	} ssc_tmr_s;

	ssc_tmr_s st;
	ssc_tmr_s next_st;

	always_comb
	begin
		next_st = st;
		next_st.done = 1'b0;
		// a retrigger restarts the full wait
		if (cal.start)
		begin
			next_st.state = SSC_CAL_RUN;
			next_st.cnt = CYCLES - 17'h00001;
		end
		else
		begin
			case (st.state)
				SSC_CAL_RUN:
					if (st.cnt == '0)
					begin
						next_st.state = SSC_CAL_IDLE;
						next_st.done = 1'b1;
					end
					else
						next_st.cnt = st.cnt - 17'h00001;
				SSC_CAL_IDLE: ;
				default: next_st.state = SSC_CAL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			st <= '{state: SSC_CAL_IDLE, cnt: '0, done: 1'b0};
		else
			st <= next_st;
	end

	assign cal.busy = (st.state == SSC_CAL_RUN);
	assign cal.done = st.done;

endmodule : ssc_cal_timer

// >>> hw/ssc_pkg.sv
package ssc_pkg;

	// register offsets on the configuration port
	localparam logic [9:0] SSC_ADDR_FB_LO = 10'h2A1;
	localparam logic [9:0] SSC_ADDR_FB_HI = 10'h2A2;
	localparam logic [9:0] SSC_ADDR_OSC_CAL = 10'h2AB;
	localparam logic [9:0] SSC_ADDR_CP_CAL = 10'h2AD;
	localparam logic [9:0] SSC_ADDR_REF_CFG = 10'h2BB;
	localparam logic [9:0] SSC_ADDR_STATUS = 10'h2BC;

	// field positions
	localparam int SSC_REF_DIV_MSB = 7;
	localparam int SSC_REF_DIV_LSB = 6;
	localparam int SSC_ST_CP_DONE = 0;
	localparam int SSC_ST_OSC_BUSY = 1;
	localparam int SSC_ST_LOCK = 3;

	// values after reset
	localparam logic [7:0] SSC_FB_LO_RST = 8'h00;
	localparam logic [7:0] SSC_FB_HI_RST = 8'h00;
	localparam logic [7:0] SSC_REF_CFG_RST = 8'h00;
	localparam logic [7:0] SSC_RDATA_RST = 8'h00;
	localparam logic [3:0] SSC_RATIO_X2_RST = 4'h2;

	// loop oscillator output is halved to give the converter clock
	localparam logic [1:0] SSC_OSC_POST_DIV = 2'h2;

	// calibration timing, worst case at the lowest comparison frequency
	localparam int SSC_CLK_MHZ = 20;
	localparam int SSC_CP_CAL_MAX_US = 4000;
	localparam int SSC_OSC_CAL_MAX_US = 2000;
	localparam int SSC_CP_CAL_CYCLES = SSC_CP_CAL_MAX_US * SSC_CLK_MHZ;
	localparam int SSC_OSC_CAL_CYCLES = SSC_OSC_CAL_MAX_US * SSC_CLK_MHZ;
	localparam int SSC_CAL_CNT_W = 17;

	typedef enum logic [1:0] {
		SSC_REF_DIV1 = 2'h0,
		SSC_REF_DIV2 = 2'h1,
		SSC_REF_DIV4 = 2'h2,
		SSC_REF_MUL2 = 2'h3
	} ssc_ref_div_e;

	typedef enum logic {
		SSC_CAL_IDLE = 1'b0,
		SSC_CAL_RUN = 1'b1
	} ssc_cal_state_e;

	// ratio times two, so that the doubler (ratio 0.5) stays an integer
	function automatic logic [3:0] ssc_ref_ratio_x2(input logic [1:0] code);
		case (ssc_ref_div_e'(code))
			SSC_REF_DIV1: ssc_ref_ratio_x2 = 4'h2;
			SSC_REF_DIV2: ssc_ref_ratio_x2 = 4'h4;
			SSC_REF_DIV4: ssc_ref_ratio_x2 = 4'h8;
			SSC_REF_MUL2: ssc_ref_ratio_x2 = 4'h1;
			default: ssc_ref_ratio_x2 = 4'h2;
		endcase
	endfunction : ssc_ref_ratio_x2

endpackage : ssc_pkg

// >>> hw/ssc_synth_cfg.sv
`timescale 1ns/100ps
module ssc_synth_cfg
	import ssc_pkg::*;
#(
	parameter int CP_CAL_CYCLES = SSC_CP_CAL_CYCLES,
	parameter int OSC_CAL_CYCLES = SSC_OSC_CAL_CYCLES
)(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// register port
	input wire logic [9:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// analog loop side
	input wire logic pll_lock_in,
	output logic [1:0] ref_div_code,
	output logic [3:0] ref_ratio_x2,
	output logic [15:0] fb_div_count,
	output logic fb_div_load,
	output logic [1:0] osc_post_div,
	output logic cp_cal_start,
	output logic osc_cal_start
);

	typedef struct packed {
		logic [7:0] fb_lo;
		logic [7:0] fb_hi;
		logic [7:0] ref_cfg;
		logic [3:0] ratio_x2;
		logic lo_wr;
		logic hi_wr;
		logic [15:0] fb_div;
		logic fb_load;
		logic [1:0] post_div;
		logic [7:0] rdata;
		logic rvalid;
		logic cp_start;
		logic osc_start;
		logic cp_done;
		logic osc_busy;
		logic osc_ok;
		logic locked;
	} ssc_top_s;

	ssc_top_s st;
	ssc_top_s next_st;
	logic [7:0] status;

	ssc_cal_if cal[2] ();

	// index 0 charge pump, index 1 loop oscillator
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_cal
			ssc_cal_timer #(
				.CYCLES(SSC_CAL_CNT_W'(gi == 0 ? CP_CAL_CYCLES : OSC_CAL_CYCLES))
			) u_tmr (
				.clock(clock),
				.nrst(nrst),
				.cal(cal[gi])
			);
		end
	endgenerate

	assign cal[0].start = st.cp_start;
	assign cal[1].start = st.osc_start;

	always_comb
	begin
		status = 8'h00;
		status[SSC_ST_CP_DONE] = st.cp_done;
		status[SSC_ST_OSC_BUSY] = st.osc_busy;
		status[SSC_ST_LOCK] = st.locked;
	end

	always_comb
	begin
		next_st = st;
		next_st.fb_load = 1'b0;
		next_st.rvalid = 1'b0;
		next_st.cp_start = 1'b0;
		next_st.osc_start = 1'b0;
		next_st.post_div = SSC_OSC_POST_DIV;
		next_st.ratio_x2 = ssc_ref_ratio_x2(st.ref_cfg[SSC_REF_DIV_MSB:SSC_REF_DIV_LSB]);
		// apply first so that a write landing in the same cycle re-arms its flag
		if (st.lo_wr && st.hi_wr)
		begin
			next_st.fb_div = {st.fb_hi, st.fb_lo};
			next_st.fb_load = 1'b1;
			next_st.lo_wr = 1'b0;
			next_st.hi_wr = 1'b0;
		end
		// calibration results, a retrigger in the same cycle overrides below
		if (cal[0].done)
			next_st.cp_done = 1'b1;
		if (cal[1].done)
		begin
			next_st.osc_busy = 1'b0;
			next_st.osc_ok = 1'b1;
		end
		if (reg_wr)
		begin
			case (reg_addr)
				SSC_ADDR_FB_LO:
				begin
					next_st.fb_lo = reg_wdata;
					next_st.lo_wr = 1'b1;
				end
				SSC_ADDR_FB_HI:
				begin
					next_st.fb_hi = reg_wdata;
					next_st.hi_wr = 1'b1;
				end
				SSC_ADDR_REF_CFG: next_st.ref_cfg = reg_wdata;
				SSC_ADDR_CP_CAL:
				begin
					next_st.cp_start = 1'b1;
					next_st.cp_done = 1'b0;
				end
				SSC_ADDR_OSC_CAL:
				begin
					next_st.osc_start = 1'b1;
					next_st.osc_busy = 1'b1;
					next_st.osc_ok = 1'b0;
				end
				default: ;
			endcase
		end
		// lock only counts once the oscillator has been calibrated
		next_st.locked = pll_lock_in && next_st.osc_ok && !next_st.osc_busy;
		if (reg_rd)
		begin
			next_st.rvalid = 1'b1;
			case (reg_addr)
				SSC_ADDR_FB_LO: next_st.rdata = st.fb_lo;
				SSC_ADDR_FB_HI: next_st.rdata = st.fb_hi;
				SSC_ADDR_REF_CFG: next_st.rdata = st.ref_cfg;
				SSC_ADDR_STATUS: next_st.rdata = status;
				default: next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			st <= '0;
			st.fb_lo <= SSC_FB_LO_RST;
			st.fb_hi <= SSC_FB_HI_RST;
			st.ref_cfg <= SSC_REF_CFG_RST;
			st.ratio_x2 <= SSC_RATIO_X2_RST;
			st.rdata <= SSC_RDATA_RST;
			st.post_div <= SSC_OSC_POST_DIV;
		end
		else
			st <= next_st;
	end

	assign reg_rdata = st.rdata;
	assign reg_rvalid = st.rvalid;
	assign ref_div_code = st.ref_cfg[SSC_REF_DIV_MSB:SSC_REF_DIV_LSB];
	assign ref_ratio_x2 = st.ratio_x2;
	assign fb_div_count = st.fb_div;
	assign fb_div_load = st.fb_load;
	assign osc_post_div = st.post_div;
	assign cp_cal_start = st.cp_start;
	assign osc_cal_start = st.osc_start;

	property p_fb_stable;
		@(posedge clock) disable iff (!nrst)
		!fb_div_load |-> fb_div_count == $past(fb_div_count);
	endproperty
	a_fb_stable: assert property (p_fb_stable) else $error("feedback count moved without load");

	property p_ref_code;
		@(posedge clock) disable iff (!nrst)
		(reg_wr && reg_addr == SSC_ADDR_REF_CFG) |=> ref_div_code == $past(reg_wdata[7:6]) ##1
			ref_ratio_x2 == ssc_ref_ratio_x2(ref_div_code);
	endproperty
	a_ref_code: assert property (p_ref_code) else $error("pre-divide code not taken");

	property p_post_div;
		@(posedge clock) disable iff (!nrst)
		osc_post_div == SSC_OSC_POST_DIV;
	endproperty
	a_post_div: assert property (p_post_div) else $error("post divider not two");

	property p_lo_rb;
		@(posedge clock) disable iff (!nrst)
		(reg_wr && reg_addr == SSC_ADDR_FB_LO) ##1 (reg_rd && reg_addr == SSC_ADDR_FB_LO && !reg_wr)
			|=> reg_rvalid && reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_lo_rb: assert property (p_lo_rb) else $error("low byte readback wrong");

	property p_apply;
		@(posedge clock) disable iff (!nrst)
		(st.lo_wr && st.hi_wr) |=> fb_div_load && fb_div_count == {$past(st.fb_hi), $past(st.fb_lo)};
	endproperty
	a_apply: assert property (p_apply) else $error("feedback count not applied");

	property p_cp_cal;
		@(posedge clock) disable iff (!nrst)
		(reg_wr && reg_addr == SSC_ADDR_CP_CAL) |=> !st.cp_done && cp_cal_start ##1 cal[0].busy;
	endproperty
	a_cp_cal: assert property (p_cp_cal) else $error("charge pump calibration not started");

	property p_osc_cal;
		@(posedge clock) disable iff (!nrst)
		$rose(st.osc_busy) |-> osc_cal_start ##1 (cal[1].busy && st.osc_busy);
	endproperty
	a_osc_cal: assert property (p_osc_cal) else $error("oscillator calibration status wrong");

	property p_osc_done;
		@(posedge clock) disable iff (!nrst)
		(cal[1].done && !(reg_wr && reg_addr == SSC_ADDR_OSC_CAL)) |=> !st.osc_busy && st.osc_ok;
	endproperty
	a_osc_done: assert property (p_osc_done) else $error("oscillator done not reported");

	property p_lock;
		@(posedge clock) disable iff (!nrst)
		st.locked |-> $past(pll_lock_in) && st.osc_ok && !st.osc_busy;
	endproperty
	a_lock: assert property (p_lock) else $error("lock shown without cause");

endmodule : ssc_synth_cfg

// >>> tb/ssc_loop_model.sv
`timescale 1ns/100ps
module ssc_loop_model
	import ssc_pkg::*;
#(
	parameter int LOCK_DELAY = 5
)(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// retune events from the block
	input wire logic fb_div_load,
	input wire logic osc_cal_start,
	// bench control
	input wire logic drop_lock,
	// lock towards the block
	output logic pll_lock_in
);
	int cnt;
	// any retune throws the loop out of lock until it settles again
	always_ff @(posedge clock)
	begin
		if (!nrst || drop_lock || fb_div_load || osc_cal_start)
		begin
			cnt <= 0;
			pll_lock_in <= 1'b0;
		end
		else if (cnt < LOCK_DELAY)
			cnt <= cnt + 1;
		else
			pll_lock_in <= 1'b1;
	end
endmodule : ssc_loop_model

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb
	import ssc_pkg::*;
;
	localparam int CP_N = 20;
	localparam int OSC_N = 10;
	logic clock, nrst, reg_wr, reg_rd, reg_rvalid, pll_lock_in, fb_div_load;
	logic cp_cal_start, osc_cal_start, drop_lock;
	logic [9:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic [1:0] ref_div_code, osc_post_div;
	logic [3:0] ref_ratio_x2;
	logic [15:0] fb_div_count;
	int num_errors = 0;
	int total_checks = 0;

	ssc_synth_cfg #(.CP_CAL_CYCLES(CP_N), .OSC_CAL_CYCLES(OSC_N)) ssc_synth_cfg_inst (.clock, .nrst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .pll_lock_in, .ref_div_code, .ref_ratio_x2,
		.fb_div_count, .fb_div_load, .osc_post_div, .cp_cal_start, .osc_cal_start);
	ssc_loop_model ssc_loop_model_inst (.clock, .nrst, .fb_div_load, .osc_cal_start, .drop_lock, .pll_lock_in);

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [9:0] a);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		check("rvalid", reg_rvalid, 1'b1);
		d = reg_rdata;
	endtask : rd

	task automatic rdchk(input logic [9:0] a, input logic [7:0] exp, input string name);
		rd(a);
		check(name, d, exp);
	endtask : rdchk

	task automatic t_reset();
		rdchk(SSC_ADDR_FB_LO, SSC_FB_LO_RST, "fb_lo_rst");
		rdchk(SSC_ADDR_FB_HI, SSC_FB_HI_RST, "fb_hi_rst");
		rdchk(SSC_ADDR_REF_CFG, SSC_REF_CFG_RST, "ref_rst");
		rdchk(SSC_ADDR_STATUS, 8'h00, "status_rst");
		rdchk(10'h3FF, 8'h00, "unmapped");
		wr(SSC_ADDR_STATUS, 8'hFF);
		rdchk(SSC_ADDR_STATUS, 8'h00, "status_ro");
		check("post_div", osc_post_div, 2'h2);
		check("ratio_rst", ref_ratio_x2, 4'h2);
	endtask : t_reset

	task automatic t_ref_div();
		logic [3:0] ratio [4] = '{4'h2, 4'h4, 4'h8, 4'h1};
		for (int i = 3; i >= 0; i--)
		begin
			wr(SSC_ADDR_REF_CFG, {i[1:0], 6'h2A});
			repeat (2) @(negedge clock);
			check("ref_code", ref_div_code, i[1:0]);
			check("ref_ratio", ref_ratio_x2, ratio[i]);
			rdchk(SSC_ADDR_REF_CFG, {i[1:0], 6'h2A}, "ref_rb");
		end
	endtask : t_ref_div

	task automatic t_fb();
		logic [15:0] n = 16'(2 * 3200 / 50);
		// 200 MHz reference divided by four keeps the comparison frequency at 50 MHz
		wr(SSC_ADDR_REF_CFG, 8'h80);
		repeat (2) @(negedge clock);
		check("ratio_div4", ref_ratio_x2, 4'h8);
		// high byte first: applying must wait for the other byte
		wr(SSC_ADDR_FB_HI, n[15:8]);
		@(negedge clock);
		check("fb_early", fb_div_load, 1'b0);
		wr(SSC_ADDR_FB_LO, n[7:0]);
		@(negedge clock);
		check("fb_load", fb_div_load, 1'b1);
		check("fb_count", fb_div_count, n);
		@(negedge clock);
		check("fb_pulse", fb_div_load, 1'b0);
		wr(SSC_ADDR_FB_LO, 8'h55);
		@(negedge clock);
		check("fb_lo_only", fb_div_load, 1'b0);
		check("fb_held", fb_div_count, n);
		wr(SSC_ADDR_FB_HI, 8'h01);
		@(negedge clock);
		check("fb_load2", fb_div_load, 1'b1);
		check("fb_count2", fb_div_count, 16'h0155);
		rdchk(SSC_ADDR_FB_LO, 8'h55, "fb_lo_rb");
		// read on the edge right after the write, as the readback property expects
		@(negedge clock);
		reg_addr = SSC_ADDR_FB_LO;
		reg_wdata = 8'h5A;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		check("b2b_rvalid", reg_rvalid, 1'b1);
		check("b2b_lo", reg_rdata, 8'h5A);
	endtask : t_fb

	task automatic t_cal(input logic [9:0] a, input int bit_no, input int cyc, input logic [7:0] busy, input string nm);
		int n = 0;
		wr(a, 8'hA5);
		check(nm, (bit_no == SSC_ST_CP_DONE) ? cp_cal_start : osc_cal_start, 1'b1);
		rdchk(SSC_ADDR_STATUS, busy, nm);
		// polling costs two cycles a read, so the count is halved
		do
		begin
			rd(SSC_ADDR_STATUS);
			n++;
		end
		while (d[bit_no] === busy[bit_no] && n < 4 * cyc);
		check(nm, n >= cyc / 2 - 1 && n <= cyc / 2 + 1, 1'b1);
		check(nm, d & 8'h03, 8'h01);
	endtask : t_cal

	task automatic t_lock();
		rdchk(SSC_ADDR_STATUS, 8'h09, "locked");
		@(negedge clock);
		drop_lock = 1'b1;
		repeat (3) @(negedge clock);
		rdchk(SSC_ADDR_STATUS, 8'h01, "unlocked");
		drop_lock = 1'b0;
		repeat (10) @(negedge clock);
		rdchk(SSC_ADDR_STATUS, 8'h09, "relocked");
	endtask : t_lock

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	initial
	begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 10'h000;
		reg_wdata = 8'h00;
		drop_lock = 1'b0;
		repeat (10) @(negedge clock);
		nrst = 1'b1;
		@(negedge clock);
		t_reset();
		t_ref_div();
		t_fb();
		// charge pump first, each calibration awaited before the next step
		t_cal(SSC_ADDR_CP_CAL, SSC_ST_CP_DONE, CP_N, 8'h00, "cp_cal");
		t_cal(SSC_ADDR_OSC_CAL, SSC_ST_OSC_BUSY, OSC_N, 8'h03, "osc_cal");
		t_lock();
		finish_test();
	end

	initial
	begin
		#(50 * 5000);
		num_errors++;
		finish_test();
	end
endmodule : tb
